// [core/tpo_pkg.sv]
// Shared constants for the timed pattern output unit
package tpo_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int TPO_AW     = 4;          // Register address width
    localparam int TPO_DW     = 8;          // Register data width
    localparam int TPO_PINS   = 16;         // Pattern pins
    localparam int TPO_GROUPS = 4;          // Groups of pins
    localparam int TPO_GW     = 4;          // Pins per group
    localparam int TPO_CHANS  = 4;          // Companion timer channels

    ////////////////////////////////////////////////////////////////////////
    // Register offsets, one byte each
    localparam logic [3:0] ADDR_MODE     = 4'h0;  // group_mode_reg
    localparam logic [3:0] ADDR_TSEL     = 4'h1;  // trigger_select_reg
    localparam logic [3:0] ADDR_NEXT_LO  = 4'h2;  // next_pattern_low
    localparam logic [3:0] ADDR_NEXT_HI  = 4'h3;  // next_pattern_high
    localparam logic [3:0] ADDR_GATE_LO  = 4'h4;  // next_gate_low
    localparam logic [3:0] ADDR_GATE_HI  = 4'h5;  // next_gate_high
    localparam logic [3:0] ADDR_DATA_LO  = 4'h6;  // port_low_data
    localparam logic [3:0] ADDR_DATA_HI  = 4'h7;  // port_high_data
    localparam logic [3:0] ADDR_DIR_LO   = 4'h8;  // port_low_direction
    localparam logic [3:0] ADDR_DIR_HI   = 4'h9;  // port_high_direction

    ////////////////////////////////////////////////////////////////////////
    // Field layout and values after reset
    localparam int         MODE_SPLIT_LSB = 0;    // Split bits 3..0
    localparam logic [7:0] MODE_RESET     = 8'hf0;
    localparam logic [3:0] MODE_RSVD_READ = 4'hf; // Bits 7..4 read as 1
    localparam logic [3:0] SPLIT_RESET    = 4'h0;
    localparam logic [7:0] TSEL_RESET     = 8'hff;
    localparam int         TSEL_FIELD_W   = 2;    // Per-group select width
    localparam logic [15:0] PIN_RESET     = 16'h0000;
    localparam logic [7:0] READ_IDLE      = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing: trigger to port data update, in clock cycles
    localparam int TRIG_TO_DATA_CYC = 1;

endpackage : tpo_pkg

// [core/tpo_group_load.sv]
`timescale 1ns/1ps
`default_nettype none

// Per-group transfer mask from the selected trigger events
module tpo_group_load
    import tpo_pkg::*;
#(
    parameter int GW = TPO_GW
) (
    // Mode and selected events
    input  wire logic          split_i,
    input  wire logic          evt_a_i,
    input  wire logic          evt_b_i,
    // Pattern and gate bits of the group
    input  wire logic [GW-1:0] next_i,
    input  wire logic [GW-1:0] gate_i,
    // Bits to copy this cycle
    output logic      [GW-1:0] load_o
);

    logic [GW-1:0] from_a;
    logic [GW-1:0] from_b;

    // Event A loads every gated bit, in either mode
    assign from_a = evt_a_i ? gate_i : '0;

    // Event B only counts when split; it moves zeros only, so falling
    // edges lead rising edges by the margin
    assign from_b = (split_i && evt_b_i) ? (gate_i & ~next_i) : '0;

    assign load_o = from_a | from_b;

endmodule : tpo_group_load

`default_nettype wire

// [core/tpo_top.sv]
//
// Behaviour
// - Mode register loads f0 on reset and hardware standby; software standby keeps it.
// - Mode bits 7..4 always read 1 and ignore writes.
// - Mode bits 3..0 pick split output for groups 3..0.
// - With split off a group updates only on match A.
// - Split mode: period sets trigger period, margin sets overlap gap; A and B act.
// - Pattern drive needs both direction and gate bit at 1.
// - Pin first shows old data; each trigger copies next bit into data.
// - Gate 1, direction 0: input pin, data read-only but still loaded.
// - Gate 0: ordinary input or output port by direction bit.
// - Input capture triggers the transfer like a compare match.
// - Transfer still happens while another function owns the pin.
// - Split mode: match A copies every gated next bit.
// - Split mode: match B copies only next bits that are 0.
// - Two-bit select per group picks channel 0..3; resets to all ones.
// - Gate bit off leaves data bit and pin unchanged at triggers.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module tpo_top
    import tpo_pkg::*;
#(
    parameter int PINS   = TPO_PINS,
    parameter int GROUPS = TPO_GROUPS,
    parameter int GW     = TPO_GW,
    parameter int CHANS  = TPO_CHANS
) (
    // Clock and resets
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic              hw_standby_i,
    // Register port
    input  wire logic [TPO_AW-1:0] addr_i,
    input  wire logic [TPO_DW-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [TPO_DW-1:0] rdata_o,
    // Companion timer events, one pulse per channel
    input  wire logic [CHANS-1:0]  match_a_i,
    input  wire logic [CHANS-1:0]  match_b_i,
    input  wire logic [CHANS-1:0]  capture_a_i,
    input  wire logic [CHANS-1:0]  capture_b_i,
    // Pins taken over by timer, memory engine or address output
    input  wire logic [PINS-1:0]   takeover_i,
    // Pulse pattern pins
    input  wire logic [PINS-1:0]   pin_i,
    output logic      [PINS-1:0]   pin_o,
    output logic      [PINS-1:0]   pin_oe_o,
    // Pins currently in pattern output
    output logic      [PINS-1:0]   pattern_active_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic              rst;
    logic [3:0]        group_split;      // group3..0_split_mode
    logic [7:0]        trigger_select;
    logic [PINS-1:0]   next_pattern_bits;
    logic [PINS-1:0]   next_gate_bits;
    logic [PINS-1:0]   port_data;
    logic [PINS-1:0]   port_direction;
    logic [PINS-1:0]   next_port_data;
    logic [PINS-1:0]   load_mask;
    logic [GROUPS-1:0] sel_a;
    logic [GROUPS-1:0] sel_b;
    logic [TPO_DW-1:0] next_rdata;
    logic              data_wr_lo;
    logic              data_wr_hi;

    // Hardware standby clears like reset; software standby is not seen
    // here, so every register simply holds through it
    assign rst = reset_i | hw_standby_i;

    assign data_wr_lo = wr_i && (addr_i == ADDR_DATA_LO);
    assign data_wr_hi = wr_i && (addr_i == ADDR_DATA_HI);

    ////////////////////////////////////////////////////////////////////////
    // Mode register: only the split bits are stored

    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            group_split <= SPLIT_RESET;
        end else if (wr_i && addr_i == ADDR_MODE) begin
            group_split <= wdata_i[MODE_SPLIT_LSB +: 4];
        end
    end

    // Trigger channel selection, two bits per group
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            trigger_select <= TSEL_RESET;
        end else if (wr_i && addr_i == ADDR_TSEL) begin
            trigger_select <= wdata_i;
        end
    end

    // Next pattern bits, written low and high byte separately
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            next_pattern_bits <= PIN_RESET;
        end else if (wr_i && addr_i == ADDR_NEXT_LO) begin
            next_pattern_bits[7:0] <= wdata_i;
        end else if (wr_i && addr_i == ADDR_NEXT_HI) begin
            next_pattern_bits[15:8] <= wdata_i;
        end
    end

    // Per-pin transfer gates
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            next_gate_bits <= PIN_RESET;
        end else if (wr_i && addr_i == ADDR_GATE_LO) begin
            next_gate_bits[7:0] <= wdata_i;
        end else if (wr_i && addr_i == ADDR_GATE_HI) begin
            next_gate_bits[15:8] <= wdata_i;
        end
    end

    // Pin directions
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            port_direction <= PIN_RESET;
        end else if (wr_i && addr_i == ADDR_DIR_LO) begin
            port_direction[7:0] <= wdata_i;
        end else if (wr_i && addr_i == ADDR_DIR_HI) begin
            port_direction[15:8] <= wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger selection and per-group transfer masks

    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : gen_group
            logic [TSEL_FIELD_W-1:0] chan;

            assign chan = trigger_select[g*TSEL_FIELD_W +: TSEL_FIELD_W];

            // Capture counts as a match on the same register
            assign sel_a[g] = match_a_i[chan] | capture_a_i[chan];
            assign sel_b[g] = match_b_i[chan] | capture_b_i[chan];

            tpo_group_load #(
                .GW      (GW)
            ) u_load (
                .split_i (group_split[g]),
                .evt_a_i (sel_a[g]),
                .evt_b_i (sel_b[g]),
                .next_i  (next_pattern_bits[g*GW +: GW]),
                .gate_i  (next_gate_bits[g*GW +: GW]),
                .load_o  (load_mask[g*GW +: GW])
            );

            // Normal mode ignores event B entirely
            normal_only_a_a: assert property (
                @(posedge ref_clk_i) disable iff (rst)
                (!group_split[g] && !sel_a[g])
                    |-> (load_mask[g*GW +: GW] == '0)
            ) else $error("normal group loaded without event A");

            // Split mode, event A: every gated bit lands
            split_a_load_a: assert property (
                @(posedge ref_clk_i) disable iff (rst)
                (group_split[g] && sel_a[g])
                    |=> (port_data[g*GW +: GW]
                         & $past(next_gate_bits[g*GW +: GW]))
                        == ($past(next_pattern_bits[g*GW +: GW])
                         & $past(next_gate_bits[g*GW +: GW]))
            ) else $error("split event A missed a gated bit");

            // Split mode, event B alone: no bit may rise
            split_b_zero_a: assert property (
                @(posedge ref_clk_i) disable iff (rst)
                (group_split[g] && sel_b[g] && !sel_a[g]
                 && !data_wr_lo && !data_wr_hi)
                    |=> (port_data[g*GW +: GW]
                         & ~$past(port_data[g*GW +: GW])) == '0
            ) else $error("split event B raised a bit");

            // Capture A on the selected channel loads a normal group
            capture_trig_a: assert property (
                @(posedge ref_clk_i) disable iff (rst)
                (capture_a_i[chan] && !group_split[g])
                    |=> (port_data[g*GW +: GW]
                         & $past(next_gate_bits[g*GW +: GW]))
                        == ($past(next_pattern_bits[g*GW +: GW])
                         & $past(next_gate_bits[g*GW +: GW]))
            ) else $error("capture did not trigger group");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Port data: transfer beats a software write in the same cycle

    always_comb begin
        next_port_data = port_data;
        for (int i = 0; i < PINS; i++) begin
            if (load_mask[i]) begin
                next_port_data[i] = next_pattern_bits[i];
            end else if (next_gate_bits[i] && !port_direction[i]) begin
                // Gated input pin: data is read-only
                next_port_data[i] = port_data[i];
            end else if (i < 8 && data_wr_lo) begin
                next_port_data[i] = wdata_i[i % 8];
            end else if (i >= 8 && data_wr_hi) begin
                next_port_data[i] = wdata_i[i % 8];
            end
        end
    end

    // Transfer lands on the edge that sees the trigger pulse
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            port_data <= PIN_RESET;
        end else begin
            port_data <= next_port_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins: data flop drives the pin directly, so no extra latency

    assign pin_o = port_data;

    // Enable follows direction; a taken-over pin is released to its owner
    // but its data bit keeps being loaded underneath
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            pin_oe_o <= PIN_RESET;
        end else begin
            pin_oe_o <= port_direction & ~takeover_i;
        end
    end

    // Pattern drive needs gate and direction both set
    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            pattern_active_o <= PIN_RESET;
        end else begin
            pattern_active_o <= port_direction & next_gate_bits
                                & ~takeover_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data valid only in the cycle after the strobe

    always_comb begin
        next_rdata = READ_IDLE;
        case (addr_i)
            ADDR_MODE:    next_rdata = {MODE_RSVD_READ, group_split};
            ADDR_TSEL:    next_rdata = trigger_select;
            ADDR_NEXT_LO: next_rdata = next_pattern_bits[7:0];
            ADDR_NEXT_HI: next_rdata = next_pattern_bits[15:8];
            ADDR_GATE_LO: next_rdata = next_gate_bits[7:0];
            ADDR_GATE_HI: next_rdata = next_gate_bits[15:8];
            // Input pins read the pin level, outputs the data bit
            ADDR_DATA_LO: next_rdata = (port_data[7:0] & port_direction[7:0])
                                     | (pin_i[7:0] & ~port_direction[7:0]);
            ADDR_DATA_HI: next_rdata = (port_data[15:8]
                                        & port_direction[15:8])
                                     | (pin_i[15:8]
                                        & ~port_direction[15:8]);
            ADDR_DIR_LO:  next_rdata = port_direction[7:0];
            ADDR_DIR_HI:  next_rdata = port_direction[15:8];
            default:      next_rdata = READ_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            rdata_o <= READ_IDLE;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= READ_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Reset and hardware standby leave the mode at its initial value
    mode_reset_val_a: assert property (
        @(posedge ref_clk_i)
        rst |=> ({MODE_RSVD_READ, group_split} == MODE_RESET)
    ) else $error("mode register not at reset value");

    // Selection resets to channel 3 for every group
    tsel_reset_val_a: assert property (
        @(posedge ref_clk_i)
        rst |=> (trigger_select == TSEL_RESET)
    ) else $error("trigger select not at reset value");

    // Reserved mode bits read as ones even after a zero write
    mode_rsvd_read_a: assert property (
        @(posedge ref_clk_i) disable iff (rst)
        (rd_i && addr_i == ADDR_MODE)
            |=> (rdata_o[7:4] == MODE_RSVD_READ)
    ) else $error("reserved mode bits not read as one");

    // Ungated bits never change without a software write
    gate_off_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (rst)
        (!data_wr_lo && !data_wr_hi)
            |=> ((port_data ^ $past(port_data))
                 & ~$past(next_gate_bits)) == '0
    ) else $error("ungated data bit changed");

    // Normal group 0 on event A: pin shows next bits one edge later
    normal_load_a: assert property (
        @(posedge ref_clk_i) disable iff (rst)
        (!group_split[0] && sel_a[0] && next_gate_bits[3:0] == 4'hf)
            |=> (pin_o[3:0] == $past(next_pattern_bits[3:0]))
    ) else $error("normal transfer not seen on pins");

    // Transfer proceeds while the pin belongs to another function
    takeover_load_a: assert property (
        @(posedge ref_clk_i) disable iff (rst)
        (takeover_i[0] && sel_a[0] && next_gate_bits[0])
            |=> (port_data[0] == $past(next_pattern_bits[0]))
    ) else $error("taken-over pin missed transfer");

    // Gated input pin ignores software writes to its data bit
    gated_input_ro_a: assert property (
        @(posedge ref_clk_i) disable iff (rst)
        (data_wr_lo && next_gate_bits[4] && !port_direction[4]
         && !load_mask[4])
            |=> $stable(port_data[4])
    ) else $error("read-only data bit was written");

    // Ungated output pin takes a software write
    plain_output_wr_a: assert property (
        @(posedge ref_clk_i) disable iff (rst)
        (data_wr_lo && !next_gate_bits[0])
            |=> (port_data[0] == $past(wdata_i[0]))
    ) else $error("plain port write lost");

    // Enable tracks direction one edge on, absent takeover
    dir_enable_a: assert property (
        @(posedge ref_clk_i) disable iff (rst)
        (port_direction[0] && !takeover_i[0])
            |=> pin_oe_o[0]
    ) else $error("pin not driven with direction set");

    // Read data stands only in the cycle after the strobe
    read_idle_a: assert property (
        @(posedge ref_clk_i) disable iff (rst)
        !rd_i |=> (rdata_o == READ_IDLE)
    ) else $error("read data outside its cycle");

endmodule : tpo_top

`default_nettype wire

// [verif/tpo_load_model.sv]
`timescale 1ns/1ps
`default_nettype none

// External loads on the pattern pins, each with a pull-up resistor
module tpo_load_model
    import tpo_pkg::*;
(
    // Pad drive from the block
    input  wire logic [TPO_PINS-1:0] drv_i,
    input  wire logic [TPO_PINS-1:0] drv_oe_i,
    // Level seen back on the pads
    output logic      [TPO_PINS-1:0] level_o
);
    // Released pins float up, so an input pin never echoes old drive
    always_comb begin
        for (int k = 0; k < TPO_PINS; k++) begin
            level_o[k] = drv_oe_i[k] ? drv_i[k] : 1'b1;
        end
    end
endmodule : tpo_load_model

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb
    import tpo_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    // Signals
    logic                ref_clk_i    = 1'b0;
    logic                reset_i      = 1'b1;
    logic                hw_standby_i = 1'b0;
    logic [TPO_AW-1:0]   addr_i       = '0;
    logic [TPO_DW-1:0]   wdata_i      = '0;
    logic                wr_i         = 1'b0;
    logic                rd_i         = 1'b0;
    logic [TPO_DW-1:0]   rdata_o;
    logic [3:0]          ev[4]        = '{default: 4'h0};
    logic [15:0]         takeover_i   = '0;
    logic [15:0]         pin_i;
    logic [15:0]         pin_o;
    logic [15:0]         pin_oe_o;
    logic [15:0]         pattern_active_o;
    logic [15:0]         exp_pin;
    int                  n_mismatch   = 0;
    int                  num_checks   = 0;
    int                  cycles       = 0;

    tpo_top dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .hw_standby_i(hw_standby_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .match_a_i(ev[0]), .match_b_i(ev[1]),
        .capture_a_i(ev[2]), .capture_b_i(ev[3]),
        .takeover_i(takeover_i), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .pattern_active_o(pattern_active_o)
    );

    tpo_load_model loads (
        .drv_i(pin_o), .drv_oe_i(pin_oe_o), .level_o(pin_i)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; tests need about 130 cycles
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic check(input string w, input logic [15:0] seen,
                         input logic [15:0] e);
        num_checks++;
        if (seen !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", w, e, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input string w);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        check(w, {8'h00, rdata_o}, {8'h00, e});
    endtask : rd

    // Kind 0 match A, 1 match B, 2 capture A, 3 capture B
    task automatic trig(input int kind, input logic [3:0] ch);
        @(posedge ref_clk_i);
        ev[kind] <= ch;
        @(posedge ref_clk_i);
        ev[kind] <= 4'h0;
        #1;
    endtask : trig

    task automatic wr16(input logic [3:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 4'h1, d[15:8]);
    endtask : wr16

    task automatic done(input string t);
        $display("test %s done", t);
    endtask : done

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(ADDR_MODE, 8'hf0, "mode reset");
        rd(ADDR_TSEL, 8'hff, "select reset");
        rd(ADDR_GATE_LO, 8'h00, "gate reset");
        rd(4'ha, 8'h00, "unmapped");
        check("pin reset", pin_o, 16'h0000);
        done("reset");

        // Reserved bits stay 1 whatever is written
        wr(ADDR_MODE, 8'hff);
        rd(ADDR_MODE, 8'hff, "mode ff");
        wr(ADDR_MODE, 8'h05);
        rd(ADDR_MODE, 8'hf5, "mode 05");
        wr(ADDR_MODE, 8'h00);
        done("mode");

        // Normal output: old data first, then match A only
        wr16(ADDR_DIR_LO, 16'hffff);
        wr16(ADDR_DATA_LO, 16'h0055);
        wr16(ADDR_GATE_LO, 16'hffff);
        wr16(ADDR_NEXT_LO, 16'ha3c5);
        @(posedge ref_clk_i);
        #1;
        check("pin initial", pin_o, 16'h0055);
        check("active", pattern_active_o, 16'hffff);
        trig(1, 4'h8);
        check("pin after B", pin_o, 16'h0055);
        trig(0, 4'h8);
        check("pin after A", pin_o, 16'ha3c5);
        exp_pin = 16'ha3c5;
        done("normal");

        // Every channel code; capture stands in for match on odd codes
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_TSEL, 8'(8'h55 * c));
            wr16(ADDR_NEXT_LO, 16'(16'h1111 * (c + 1)));
            trig(0, 4'(1 << (c ^ 1)));
            check("other channel", pin_o, exp_pin);
            trig((c % 2) * 2, 4'(1 << c));
            exp_pin = 16'(16'h1111 * (c + 1));
            check("own channel", pin_o, exp_pin);
        end
        done("select");

        // Low byte: bits 1..0 pattern, 3..2 output, 5..4 locked input
        wr(ADDR_DIR_LO, 8'h0f);
        wr(ADDR_GATE_LO, 8'h33);
        wr(ADDR_DATA_LO, 8'hff);
        #1;
        check("data write", pin_o, 16'h44cf);
        check("enable", pin_oe_o, 16'hff0f);
        check("active", pattern_active_o, 16'hff03);
        rd(ADDR_DATA_LO, 8'hff, "input read");
        wr(ADDR_NEXT_LO, 8'h00);
        trig(0, 4'h8);
        check("gated load", pin_o, 16'h44cc);
        done("gate");

        // Split output: B clears zeros early, A sets ones later
        wr(ADDR_MODE, 8'h0f);
        wr(ADDR_GATE_LO, 8'hff);
        wr(ADDR_DIR_LO, 8'hff);
        wr16(ADDR_DATA_LO, 16'h00ff);
        wr16(ADDR_NEXT_LO, 16'h0f0f);
        trig(3, 4'h8);
        check("split B", pin_o, 16'h000f);
        trig(0, 4'h8);
        check("split A", pin_o, 16'h0f0f);
        done("split");

        // Group 0 alone split: B clears its zeros, other groups ignore B
        wr(ADDR_MODE, 8'h01);
        wr16(ADDR_NEXT_LO, 16'hf0f0);
        trig(1, 4'h8);
        check("mixed B", pin_o, 16'h0f00);
        done("mixed");

        // Pins owned elsewhere still take the transfer
        @(posedge ref_clk_i);
        takeover_i <= 16'hffff;
        wr16(ADDR_NEXT_LO, 16'hf0f0);
        #1;
        check("takeover oe", pin_oe_o, 16'h0000);
        check("takeover act", pattern_active_o, 16'h0000);
        trig(0, 4'h8);
        check("takeover load", pin_o, 16'hf0f0);
        @(posedge ref_clk_i);
        takeover_i <= 16'h0000;
        done("takeover");

        // Hardware standby reloads the mode register
        hw_standby_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        hw_standby_i <= 1'b0;
        rd(ADDR_MODE, 8'hf0, "mode standby");
        check("pin standby", pin_o, 16'h0000);
        done("standby");
        close_out();
    end
endmodule : tb

`default_nettype wire
